// ---- rtl/msp_defs.svh ----
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH
// Timing
`define MSP_CLK_HZ 250000000
`define MSP_BIT_RATE_HZ 31250
`define MSP_BIT_CYCLES (`MSP_CLK_HZ / `MSP_BIT_RATE_HZ)
// Buffers
`define MSP_FIFO_AW 4
`define MSP_FIFO_DEPTH 5'h10
`define MSP_BUF_DEPTH 5'h01
// Register byte offsets
`define MSP_OFF_DATA 12'h000
`define MSP_OFF_STATCMD 12'h004
`define MSP_OFF_CTRL 12'h008
`define MSP_EXT_WINDOW 3
// Control fields
`define MSP_CTL_LOOP 0
`define MSP_CTL_ECHO 1
`define MSP_CTL_PTFIFO 2
`define MSP_CTL_PTTX 4
`define MSP_CTL_RESET 8'h00
// Status fields
`define MSP_ST_RXEMPTY 7
`define MSP_ST_TXFULL 6
`define MSP_ST_RXFULL 5
`define MSP_ST_OVR 3
`define MSP_ST_TXEMPTY 2
`define MSP_ST_MODE 0
// Commands and answers
`define MSP_CMD_UART 8'h3F
`define MSP_CMD_RESET 8'hFF
`define MSP_CMD_ID_AB 8'hAB
`define MSP_CMD_ID_AC 8'hAC
`define MSP_CMD_ID_AD 8'hAD
`define MSP_CMD_ID_AF 8'hAF
`define MSP_CMD_ID_A0 5'h14
`define MSP_ACK 8'hFE
`define MSP_ID_DATA_A0 8'h00
`define MSP_ID_DATA_AC 8'h15
`define MSP_ID_DATA_AD 8'h01
`define MSP_ID_DATA_AF 8'h64
`endif

// ---- rtl/msp_mem.sv ----
`timescale 1ns/10ps
module msp_mem #(
    parameter int WIDTH = 8,
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    typedef struct packed {
        logic [(1<<AW)-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0] rdata;
    } msp_mem_st_t;
    msp_mem_st_t mem_reg;
    msp_mem_st_t mem_next;

    // Read data registered; a fresh write shows one edge later
    always_comb
    begin
        mem_next = mem_reg;
        mem_next.rdata = mem_reg.cells[rd_addr];
        if (wr_en)
        begin
            mem_next.cells[wr_addr] = wr_data;
        end
    end

    // Contents carry no reset, as in a real RAM
    always_ff @(posedge pclk)
    begin
        mem_reg <= mem_next;
    end

    assign rd_data = mem_reg.rdata;
endmodule

// ---- rtl/msp_pkg.sv ----
`include "msp_defs.svh"
package msp_pkg;
    typedef enum logic {MSP_PASS, MSP_UART} msp_mode_t;
    typedef enum logic [2:0] {MSP_TX_IDLE, MSP_TX_LOAD, MSP_TX_START, MSP_TX_DATA,
        MSP_TX_STOP} msp_tx_t;
    typedef enum logic [1:0] {MSP_RX_IDLE, MSP_RX_START, MSP_RX_DATA, MSP_RX_STOP} msp_rx_t;
    typedef struct packed {
        msp_mode_t mode;
        logic [7:0] ctrl;
        logic ovr;
        logic rx_block;
        logic cmd_pend;
        logic [7:0] cmd_byte;
        logic [1:0] resp_cnt;
        logic [7:0] resp0;
        logic [7:0] resp1;
        logic [3:0] rxf_wp;
        logic [3:0] rxf_rp;
        logic [4:0] rxf_cnt;
        logic [3:0] txf_wp;
        logic [3:0] txf_rp;
        logic [4:0] txf_cnt;
        msp_tx_t tx_st;
        logic [15:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_line;
        msp_rx_t rx_st;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic [2:0] rx_sync;
        logic rx_level;
        logic pin;
        logic wait_done;
        logic [31:0] prdata;
    } msp_state_t;
endpackage

// ---- rtl/msp_port.sv ----
`timescale 1ns/10ps
// Functional notes
// RULE_01: Fixed 31.25 kbit/s rate both directions
// RULE_02: Frame is start, eight data, stop
// RULE_03: Legacy functions in two-word register window
// RULE_04: Control register only with three-word window
// RULE_05: Command register write decoded as command
// RULE_06: Two modes, pass-through by default
// RULE_07: Transmitter serialises bytes from transmit buffer
// RULE_08: Receiver assembles bytes into receive buffer
// RULE_09: High input line is idle
// RULE_10: Control register selects signal routing
// RULE_11: FIFOs decouple bus from serial engine
// RULE_12: Bus unit serves all register accesses
// RULE_13: Idle high, start low, LSB first
// RULE_14: Centre sampling, unconfirmed start discarded
// RULE_15: Pass-through transmit off until control bit4
// RULE_16: Pass-through commands queue acknowledge bytes
// RULE_17: UART mode: only FFh acts, resets port
// RULE_18: Sixteen-byte receive FIFO drops when full
module msp_port
    import msp_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = `MSP_BIT_CYCLES,
    parameter int unsigned ADDR_WINDOW = `MSP_EXT_WINDOW
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic uart_mode
);
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2 - 1);
    localparam bit EXT_OK = (ADDR_WINDOW >= `MSP_EXT_WINDOW);

    function automatic msp_state_t init_st();
        msp_state_t t;
        t = '0;
        t.mode = MSP_PASS;
        t.ctrl = `MSP_CTL_RESET;
        t.tx_st = MSP_TX_IDLE;
        t.rx_st = MSP_RX_IDLE;
        t.tx_line = 1'b1;
        t.rx_level = 1'b1;
        t.rx_sync = 3'h7;
        t.pin = 1'b1;
        return t;
    endfunction
    localparam msp_state_t ST_INIT = init_st();

    msp_state_t s_reg;
    msp_state_t s_next;
    logic [7:0] rx_rdata;
    logic [7:0] tx_rdata;
    logic rx_we;
    logic [7:0] rx_wdata;
    logic tx_we;
    logic access;
    logic hit;
    logic done;
    logic wr_data;
    logic wr_cmd;
    logic wr_ctrl;
    logic rd_data;
    logic rd_stat;
    logic rx_fifo_on;
    logic tx_fifo_on;
    logic rx_full;
    logic tx_full;
    logic tx_accept;
    logic rx_src;
    logic rx_push;
    logic rx_pop;
    logic ovr_set;
    logic exec;
    logic [7:0] status;

    // Receive and transmit storage
    msp_mem #(.WIDTH(8), .AW(`MSP_FIFO_AW)) rx_mem (
        .pclk(pclk),
        .wr_en(rx_we),
        .wr_addr(s_reg.rxf_wp),
        .wr_data(rx_wdata),
        .rd_addr(s_reg.rxf_rp),
        .rd_data(rx_rdata)
    );
    msp_mem #(.WIDTH(8), .AW(`MSP_FIFO_AW)) tx_mem (
        .pclk(pclk),
        .wr_en(tx_we),
        .wr_addr(s_reg.txf_wp),
        .wr_data(pwdata[7:0]),
        .rd_addr(s_reg.txf_rp),
        .rd_data(tx_rdata)
    );

    // RULE_12: bus unit decode
    always_comb
    begin
        access = psel && penable;
        // RULE_03 RULE_04: window decode
        hit = (paddr == `MSP_OFF_DATA) || (paddr == `MSP_OFF_STATCMD)
            || (EXT_OK && paddr == `MSP_OFF_CTRL);
        done = access && s_reg.wait_done;
        pready = done;
        pslverr = done && !hit;
        wr_data = done && pwrite && pstrb[0] && paddr == `MSP_OFF_DATA;
        wr_cmd = done && pwrite && pstrb[0] && paddr == `MSP_OFF_STATCMD;
        wr_ctrl = done && pwrite && pstrb[0] && EXT_OK && paddr == `MSP_OFF_CTRL;
        rd_data = done && !pwrite && paddr == `MSP_OFF_DATA;
        rd_stat = done && !pwrite && paddr == `MSP_OFF_STATCMD;
    end

    always_comb
    begin
        s_next = s_reg;
        rx_push = 1'b0;
        rx_we = 1'b0;
        rx_wdata = s_reg.rx_sh;
        tx_we = 1'b0;
        // RULE_11: FIFO depth per mode
        rx_fifo_on = s_reg.mode == MSP_UART || s_reg.ctrl[`MSP_CTL_PTFIFO];
        tx_fifo_on = s_reg.mode == MSP_UART;
        rx_full = s_reg.rxf_cnt >= (rx_fifo_on ? `MSP_FIFO_DEPTH : `MSP_BUF_DEPTH);
        tx_full = s_reg.txf_cnt >= (tx_fifo_on ? `MSP_FIFO_DEPTH : `MSP_BUF_DEPTH);
        // RULE_15: pass-through transmit gate
        tx_accept = s_reg.mode == MSP_UART || s_reg.ctrl[`MSP_CTL_PTTX];
        status = {s_reg.rxf_cnt == 5'h00, tx_full, rx_fifo_on && rx_full, 1'b0, s_reg.ovr,
            tx_fifo_on && s_reg.txf_cnt == 5'h00, 1'b0, s_reg.mode == MSP_UART};

        // Data captured in the first access cycle, so fresh writes have settled
        if (access && !s_reg.wait_done)
        begin
            s_next.wait_done = 1'b1;
            s_next.prdata = 32'h0000_0000;
            if (paddr == `MSP_OFF_DATA)
            begin
                s_next.prdata[7:0] = rx_rdata;
            end
            else if (paddr == `MSP_OFF_STATCMD)
            begin
                s_next.prdata[7:0] = status;
            end
            else if (EXT_OK && paddr == `MSP_OFF_CTRL)
            begin
                s_next.prdata[7:0] = s_reg.ctrl;
            end
        end
        if (done)
        begin
            s_next.wait_done = 1'b0;
        end
        // RULE_10: control register write
        if (wr_ctrl)
        begin
            s_next.ctrl = pwdata[7:0];
        end
        // RULE_05: command latched, runs when engine idle
        if (wr_cmd)
        begin
            s_next.cmd_pend = 1'b1;
            s_next.cmd_byte = pwdata[7:0];
        end

        // Pin synchroniser; a change counts once stages two and three agree
        s_next.rx_sync = {s_reg.rx_sync[1:0], serial_in_pin};
        if (s_reg.rx_sync[1] == s_reg.rx_sync[2])
        begin
            s_next.rx_level = s_reg.rx_sync[2];
        end
        // RULE_10: loopback and echo routing
        rx_src = s_reg.ctrl[`MSP_CTL_LOOP] ? s_reg.tx_line : s_reg.rx_level;
        s_next.pin = s_reg.ctrl[`MSP_CTL_ECHO] ? s_reg.rx_level : s_reg.tx_line;

        // RULE_08: receive engine
        case (s_reg.rx_st)
            MSP_RX_IDLE:
            begin
                // RULE_09: high line stays idle
                if (!rx_src)
                begin
                    s_next.rx_st = MSP_RX_START;
                    s_next.rx_cnt = BIT_HALF;
                end
            end
            MSP_RX_START:
            begin
                if (s_reg.rx_cnt != 16'h0000)
                begin
                    s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
                end
                // RULE_14: start confirmed at its centre
                else if (!rx_src)
                begin
                    s_next.rx_st = MSP_RX_DATA;
                    s_next.rx_cnt = BIT_LAST;
                    s_next.rx_bit = 3'h0;
                end
                else
                begin
                    s_next.rx_st = MSP_RX_IDLE;
                end
            end
            MSP_RX_DATA:
            begin
                if (s_reg.rx_cnt != 16'h0000)
                begin
                    s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
                end
                else
                begin
                    // RULE_02: eight data bits, LSB first
                    s_next.rx_sh = {rx_src, s_reg.rx_sh[7:1]};
                    s_next.rx_bit = s_reg.rx_bit + 3'h1;
                    s_next.rx_cnt = BIT_LAST;
                    if (s_reg.rx_bit == 3'h7)
                    begin
                        s_next.rx_st = MSP_RX_STOP;
                    end
                end
            end
            default:
            begin
                if (s_reg.rx_cnt != 16'h0000)
                begin
                    s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
                end
                else
                begin
                    // Bad stop bit is a framing error; byte dropped
                    s_next.rx_st = MSP_RX_IDLE;
                    rx_push = rx_src && !s_reg.rx_block;
                end
            end
        endcase

        // RULE_07: transmit engine, RULE_01: fixed bit period
        case (s_reg.tx_st)
            MSP_TX_IDLE:
            begin
                if (s_reg.txf_cnt != 5'h00)
                begin
                    s_next.tx_st = MSP_TX_LOAD;
                end
            end
            MSP_TX_LOAD:
            begin
                // RULE_13: start bit low
                s_next.tx_sh = tx_rdata;
                s_next.txf_rp = s_reg.txf_rp + 4'h1;
                s_next.tx_line = 1'b0;
                s_next.tx_cnt = BIT_LAST;
                s_next.tx_st = MSP_TX_START;
            end
            MSP_TX_START, MSP_TX_DATA:
            begin
                if (s_reg.tx_cnt != 16'h0000)
                begin
                    s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
                end
                else if (s_reg.tx_st == MSP_TX_START)
                begin
                    s_next.tx_st = MSP_TX_DATA;
                    s_next.tx_line = s_reg.tx_sh[0];
                    s_next.tx_bit = 3'h0;
                    s_next.tx_cnt = BIT_LAST;
                end
                // RULE_13: stop bit high after eighth bit
                else if (s_reg.tx_bit == 3'h7)
                begin
                    s_next.tx_st = MSP_TX_STOP;
                    s_next.tx_line = 1'b1;
                    s_next.tx_cnt = BIT_LAST;
                end
                else
                begin
                    s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
                    s_next.tx_line = s_reg.tx_sh[1];
                    s_next.tx_bit = s_reg.tx_bit + 3'h1;
                    s_next.tx_cnt = BIT_LAST;
                end
            end
            default:
            begin
                if (s_reg.tx_cnt != 16'h0000)
                begin
                    s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
                end
                else
                begin
                    s_next.tx_st = MSP_TX_IDLE;
                end
            end
        endcase

        // RULE_18: full receive buffer keeps old bytes
        ovr_set = rx_push && rx_full;
        if (rx_push && !rx_full)
        begin
            rx_we = 1'b1;
        end
        else if (!rx_push && s_reg.resp_cnt != 2'h0 && !rx_full)
        begin
            // RULE_16: answers wait for room, serial data first
            rx_we = 1'b1;
            rx_wdata = s_reg.resp0;
            s_next.resp0 = s_reg.resp1;
            s_next.resp_cnt = s_reg.resp_cnt - 2'h1;
        end
        rx_pop = rd_data && s_reg.rxf_cnt != 5'h00;
        s_next.rxf_wp = s_reg.rxf_wp + 4'(rx_we);
        s_next.rxf_rp = s_reg.rxf_rp + 4'(rx_pop);
        s_next.rxf_cnt = s_reg.rxf_cnt + 5'(rx_we) - 5'(rx_pop);
        if (rd_data)
        begin
            s_next.rx_block = 1'b0;
        end
        // Overrun set wins over the read clear
        s_next.ovr = (s_reg.ovr && !(rd_stat && s_reg.prdata[`MSP_ST_OVR])) || ovr_set;
        // RULE_15: data writes ignored while transmit disabled
        tx_we = wr_data && tx_accept && !tx_full;
        s_next.txf_wp = s_reg.txf_wp + 4'(tx_we);
        s_next.txf_cnt = s_reg.txf_cnt + 5'(tx_we) - 5'(s_reg.tx_st == MSP_TX_LOAD);

        // Commands wait until no byte is in flight
        exec = s_reg.cmd_pend && s_reg.tx_st == MSP_TX_IDLE && s_reg.rx_st == MSP_RX_IDLE
            && s_reg.resp_cnt == 2'h0;
        if (exec)
        begin
            // A command written in this cycle stays pending
            s_next.cmd_pend = wr_cmd;
            if (s_reg.cmd_byte == `MSP_CMD_RESET)
            begin
                // RULE_17: port back to initial state
                s_next.mode = MSP_PASS;
                s_next.ctrl = `MSP_CTL_RESET;
                s_next.ovr = 1'b0;
                s_next.rx_block = 1'b0;
                s_next.rxf_wp = 4'h0;
                s_next.rxf_rp = 4'h0;
                s_next.rxf_cnt = 5'h00;
                s_next.txf_wp = 4'h0;
                s_next.txf_rp = 4'h0;
                s_next.txf_cnt = 5'h00;
            end
            // RULE_16: pass-through answers
            if (s_reg.mode == MSP_PASS)
            begin
                s_next.resp_cnt = 2'h2;
                s_next.resp0 = `MSP_ACK;
                s_next.resp1 = `MSP_ID_DATA_A0;
                case (s_reg.cmd_byte)
                    `MSP_CMD_UART:
                    begin
                        // RULE_06: UART entry; buffer lost without FIFO
                        s_next.mode = MSP_UART;
                        s_next.resp_cnt = 2'h1;
                        s_next.rx_block = 1'b1;
                        if (!s_reg.ctrl[`MSP_CTL_PTFIFO])
                        begin
                            s_next.rxf_wp = 4'h0;
                            s_next.rxf_rp = 4'h0;
                            s_next.rxf_cnt = 5'h00;
                        end
                    end
                    `MSP_CMD_ID_AB:
                    begin
                        s_next.resp1 = `MSP_ID_DATA_A0;
                    end
                    `MSP_CMD_ID_AC:
                    begin
                        s_next.resp1 = `MSP_ID_DATA_AC;
                    end
                    `MSP_CMD_ID_AD:
                    begin
                        s_next.resp1 = `MSP_ID_DATA_AD;
                    end
                    `MSP_CMD_ID_AF:
                    begin
                        s_next.resp1 = `MSP_ID_DATA_AF;
                    end
                    default:
                    begin
                        if (s_reg.cmd_byte[7:3] != `MSP_CMD_ID_A0)
                        begin
                            s_next.resp_cnt = 2'h1;
                        end
                    end
                endcase
            end
        end
    end

    // RULE_06: reset lands in pass-through
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= ST_INIT;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign serial_out_pin = s_reg.pin;
    assign uart_mode = s_reg.mode == MSP_UART;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [15:0] start_len;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_len <= 16'h0000;
        end
        else
        begin
            start_len <= (s_reg.tx_st == MSP_TX_START) ? start_len + 16'h0001 : 16'h0000;
        end
    end

    bit_period_a: // RULE_01
    assert property ((s_reg.tx_st == MSP_TX_START && s_next.tx_st == MSP_TX_DATA)
        |-> start_len == BIT_LAST) else $error("start bit length wrong");
    frame_bits_a: // RULE_02
    assert property ((s_reg.tx_st == MSP_TX_DATA && s_next.tx_st == MSP_TX_STOP)
        |-> s_reg.tx_bit == 3'h7 ##1 s_reg.tx_line) else $error("frame bit count wrong");
    legacy_window_a: // RULE_03
    assert property ((done && (paddr == `MSP_OFF_DATA || paddr == `MSP_OFF_STATCMD))
        |-> !pslverr) else $error("legacy register refused");
    ext_window_a: // RULE_04
    assert property ((done && paddr == `MSP_OFF_CTRL) |-> pslverr == !EXT_OK)
        else $error("control window decode wrong");
    cmd_taken_a: // RULE_05
    assert property (wr_cmd |=> s_reg.cmd_pend && s_reg.cmd_byte == $past(pwdata[7:0]))
        else $error("command not latched");
    reset_cmd_a: // RULE_17
    assert property ((exec && s_reg.cmd_byte == `MSP_CMD_RESET)
        |=> s_reg.mode == MSP_PASS && s_reg.txf_cnt == 5'h00) else $error("reset cmd failed");
    uart_ack_a: // RULE_16
    assert property ((exec && s_reg.mode == MSP_PASS && s_reg.cmd_byte == `MSP_CMD_UART)
        |=> uart_mode && s_reg.resp_cnt == 2'h1 && s_reg.resp0 == `MSP_ACK)
        else $error("uart entry ack missing");
    tx_start_low_a: // RULE_13
    assert property ((s_reg.tx_st == MSP_TX_LOAD) |=> (!s_reg.tx_line)[*2])
        else $error("start bit not low");
    rx_idle_a: // RULE_09
    assert property ((s_reg.rx_st == MSP_RX_IDLE && rx_src) |=> s_reg.rx_st == MSP_RX_IDLE)
        else $error("idle line started receive");
    rx_verify_a: // RULE_14
    assert property ((s_reg.rx_st == MSP_RX_START && s_reg.rx_cnt == 16'h0000 && rx_src)
        |=> s_reg.rx_st == MSP_RX_IDLE) else $error("false start accepted");
    rx_drop_a: // RULE_18
    assert property ((rx_push && rx_full && !rx_pop) |=> $stable(s_reg.rxf_cnt) && s_reg.ovr)
        else $error("full fifo accepted byte");
    pt_tx_off_a: // RULE_15
    assert property ((wr_data && !tx_accept) |=> s_reg.txf_cnt <= $past(s_reg.txf_cnt))
        else $error("disabled transmit took data");
endmodule

// ---- test/midi_serial_port_tb.sv ----
`timescale 1ns/10ps
`include "msp_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module midi_serial_port_tb;
    localparam int BC = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rd;
    logic pready, pslverr, serial_in_pin, serial_out_pin, uart_mode, er, m;
    logic [7:0] b, t[3];
    logic [7:0] mq[$];
    logic [7:0] cmds[8] = '{8'hA0, 8'hA7, 8'hAB, 8'hAC, 8'hAD, 8'hAF, 8'h55, 8'hFF};
    int bad_count = 0;
    int n_tests = 0;
    initial
    begin
        forever #2 pclk = ~pclk;
    end
    msp_port #(.BIT_CYCLES(BC), .ADDR_WINDOW(3)) msp_port_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .uart_mode(uart_mode));
    msp_dev #(.BC(BC)) msp_dev_i (.pclk(pclk), .rx_line(serial_out_pin), .tx_line(serial_in_pin));
    task automatic end_of_test();
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i <= 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
            if (i == 20)
            begin
                bad_count++;
                end_of_test();
            end
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rx();
        for (int i = 0; i <= 80; i++)
        begin
            apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
            if (rd[7] === 1'b0)
                break;
            if (i == 80)
            begin
                bad_count++;
                end_of_test();
            end
        end
    endtask
    task automatic pop();
        apb(1'b0, `MSP_OFF_DATA, 8'h00);
        b = mq.pop_front();
    endtask
    // Model of the command decoder
    task automatic cmd(input logic [7:0] c);
        apb(1'b1, `MSP_OFF_STATCMD, c);
        if (m == 1'b0)
        begin
            mq.push_back(`MSP_ACK);
            case (c)
                `MSP_CMD_ID_AC: mq.push_back(`MSP_ID_DATA_AC);
                `MSP_CMD_ID_AD: mq.push_back(`MSP_ID_DATA_AD);
                `MSP_CMD_ID_AF: mq.push_back(`MSP_ID_DATA_AF);
                `MSP_CMD_UART: m = 1'b1;
                default: if (c[7:3] == `MSP_CMD_ID_A0 || c == `MSP_CMD_ID_AB)
                    mq.push_back(`MSP_ID_DATA_A0);
            endcase
        end
        else if (c == `MSP_CMD_RESET)
            m = 1'b0;
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i <= 40 * BC * n; i++)
        begin
            @(posedge pclk);
            if (msp_dev_i.got_q.size() >= n)
                break;
            if (i == 40 * BC * n)
            begin
                bad_count++;
                end_of_test();
            end
        end
    endtask
    initial
    begin
        m = 1'b0;
        b = 8'($urandom(28461));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
        `CHK(rd[7:0] & 8'h81, 8'h80)
        apb(1'b0, `MSP_OFF_CTRL, 8'h00);
        `CHK(rd[7:0], `MSP_CTL_RESET)
        apb(1'b0, 12'h00C, 8'h00);
        `CHK(er, 1'b1)
        apb(1'b1, `MSP_OFF_DATA, 8'h5A);
        repeat (12 * BC) @(posedge pclk);
        `CHK(msp_dev_i.got_q.size(), 0)
        foreach (cmds[k])
        begin
            cmd(cmds[k]);
            wait_rx();
            while (mq.size() > 0)
            begin
                pop();
                `CHK(rd[7:0], b)
            end
            apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
            `CHK(rd[7], 1'b1)
        end
        apb(1'b1, `MSP_OFF_CTRL, 8'h10);
        t[0] = 8'($urandom);
        apb(1'b1, `MSP_OFF_DATA, t[0]);
        wait_got(1);
        `CHK(msp_dev_i.got_q.pop_front(), t[0])
        mq.push_back(8'($urandom));
        msp_dev_i.send(mq[0]);
        wait_rx();
        pop();
        `CHK(rd[7:0], b)
        msp_dev_i.glitch();
        repeat (20 * BC) @(posedge pclk);
        apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
        `CHK(rd[7], 1'b1)
        cmd(`MSP_CMD_UART);
        wait_rx();
        pop();
        `CHK(rd[7:0], b)
        `CHK(uart_mode, 1'b1)
        for (int k = 0; k < 3; k++)
        begin
            t[k] = 8'($urandom);
            apb(1'b1, `MSP_OFF_DATA, t[k]);
        end
        wait_got(3);
        for (int k = 0; k < 3; k++)
            `CHK(msp_dev_i.got_q.pop_front(), t[k])
        cmd(8'hAC);
        repeat (20) @(posedge pclk);
        apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
        `CHK(rd[7], 1'b1)
        for (int k = 0; k < 17; k++)
        begin
            b = 8'($urandom);
            msp_dev_i.send(b);
            if (k < 16)
                mq.push_back(b);
        end
        repeat (2 * BC) @(posedge pclk);
        apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
        `CHK(rd[7:0] & 8'hA9, 8'h29)
        apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
        `CHK(rd[3], 1'b0)
        for (int k = 0; k < 16; k++)
        begin
            pop();
            `CHK(rd[7:0], b)
        end
        cmd(`MSP_CMD_RESET);
        repeat (20) @(posedge pclk);
        `CHK(uart_mode, 1'b0)
        apb(1'b0, `MSP_OFF_STATCMD, 8'h00);
        `CHK(rd[7], 1'b1)
        apb(1'b0, `MSP_OFF_CTRL, 8'h00);
        `CHK(rd[7:0], `MSP_CTL_RESET)
        // Loopback and echo routing together
        apb(1'b1, `MSP_OFF_CTRL, 8'h13);
        t[0] = 8'($urandom);
        mq.push_back(t[0]);
        apb(1'b1, `MSP_OFF_DATA, t[0]);
        wait_rx();
        pop();
        `CHK(rd[7:0], b)
        t[1] = 8'($urandom);
        msp_dev_i.send(t[1]);
        wait_got(1);
        `CHK(msp_dev_i.got_q.pop_front(), t[1])
        `CHK(msp_dev_i.bad_frames, 0)
        end_of_test();
    end
endmodule

// ---- test/msp_dev.sv ----
`timescale 1ns/10ps
module msp_dev #(
    parameter int BC = 16
) (
    input wire logic pclk,
    input wire logic rx_line,
    output logic tx_line
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    int bad_frames = 0;
    initial
    begin
        tx_line = 1'b1;
    end
    always
    begin
        @(negedge rx_line);
        repeat (BC / 2) @(posedge pclk);
        if (rx_line == 1'b0)
        begin
            for (int i = 0; i < 8; i++)
            begin
                repeat (BC) @(posedge pclk);
                sh[i] = rx_line;
            end
            repeat (BC) @(posedge pclk);
            if (rx_line)
                got_q.push_back(sh);
            else
                bad_frames++;
        end
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge pclk);
            tx_line <= fr[i];
            repeat (BC - 1) @(posedge pclk);
        end
    endtask
    // Short low pulse, never a start
    task automatic glitch();
        @(posedge pclk);
        tx_line <= 1'b0;
        repeat (3) @(posedge pclk);
        tx_line <= 1'b1;
    endtask
endmodule
